// File: logic/mtc_pkg.sv
package mtc_pkg;
  // register page and addresses
  localparam logic [7:0] MTC_PAGE = 8'h02;
  localparam logic [7:0] MTC_ADDR_DATA_LOW = 8'hC2;
  localparam logic [7:0] MTC_ADDR_DATA_MIDDLE = 8'hC3;
  localparam logic [7:0] MTC_ADDR_DATA_HIGH = 8'hC4;
  localparam logic [7:0] MTC_ADDR_CONTROL = 8'hC5;
  // control field positions
  localparam int MTC_BIT_READY = 7;
  localparam int MTC_BIT_ERROR = 6;
  localparam int MTC_BIT_FWD = 5;
  localparam int MTC_BIT_REV = 4;
  localparam int MTC_BIT_DMA = 2;
  localparam int MTC_BIT_ENDIAN = 1;
  localparam int MTC_BIT_MODE = 0;
  // writable control bits: fwd, rev, dma, endian, mode
  localparam logic [7:0] MTC_CTRL_WMASK = 8'h37;
  // reset values
  localparam logic [7:0] MTC_CTRL_RESET = 8'h00;
  localparam logic [7:0] MTC_DATA_RESET = 8'h00;
  // operation latency in clocks
  localparam logic [1:0] MTC_OP_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    MTC_IDLE = 2'b00,
    MTC_BUSY = 2'b01,
    MTC_DONE = 2'b10
  } mtc_state_t;
endpackage : mtc_pkg

// File: logic/mtc_coder.sv
`timescale 1ns/1ns
module mtc_coder
  import mtc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus from the core
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // dma side: byte write of input data only
  input wire logic dma_wr,
  input wire logic [1:0] dma_idx,
  input wire logic [7:0] dma_wdata,
  // status levels
  output logic busy
);

  logic [7:0] ctrl_reg;
  logic [7:0] data_low_reg;
  logic [7:0] data_mid_reg;
  logic [7:0] data_high_reg;
  logic ready_reg;
  logic error_reg;
  logic op_decode_reg;
  logic [1:0] cnt_reg;
  mtc_state_t state_reg;
  logic [23:0] result;
  logic result_err;
  logic hit_page;
  logic wr_ctrl;
  logic start_fwd;
  logic start_rev;
  logic [7:0] lane_sel [3];

  // only accesses on our page respond; unused addresses are ignored
  assign hit_page = (reg_page == MTC_PAGE);
  assign wr_ctrl = reg_wr && hit_page && (reg_addr == MTC_ADDR_CONTROL);
  assign start_fwd = wr_ctrl && reg_wdata[MTC_BIT_FWD];
  assign start_rev = wr_ctrl && reg_wdata[MTC_BIT_REV] && !reg_wdata[MTC_BIT_FWD];

  // 3-of-6 symbol for one nibble
  function automatic logic [5:0] enc36(input logic [3:0] n);
    logic [5:0] s;
    s = 6'h00;
    unique case (n)
      4'h0: s = 6'h16;
      4'h1: s = 6'h0D;
      4'h2: s = 6'h0E;
      4'h3: s = 6'h0B;
      4'h4: s = 6'h1C;
      4'h5: s = 6'h19;
      4'h6: s = 6'h1A;
      4'h7: s = 6'h13;
      4'h8: s = 6'h2C;
      4'h9: s = 6'h25;
      4'hA: s = 6'h26;
      4'hB: s = 6'h23;
      4'hC: s = 6'h34;
      4'hD: s = 6'h31;
      4'hE: s = 6'h32;
      4'hF: s = 6'h29;
    endcase
    return s;
  endfunction : enc36

  // inverse lookup; bit 4 flags an invalid symbol
  function automatic logic [4:0] dec36(input logic [5:0] s);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (enc36(4'(i)) == s) begin
        r = {1'b0, 4'(i)};
      end
    end
    return r;
  endfunction : dec36

  // Manchester: each data bit becomes bit,~bit; low 12 bits of input encode
  // into 24 bits. decoding flags any pair that is not complementary.
  always_comb begin
    logic [4:0] d0;
    logic [4:0] d1;
    logic [4:0] d2;
    logic [4:0] d3;
    logic [23:0] in24;
    d0 = 5'h00;
    d1 = 5'h00;
    d2 = 5'h00;
    d3 = 5'h00;
    in24 = {data_high_reg, data_mid_reg, data_low_reg};
    result = 24'h000000;
    result_err = 1'b0;
    if (!op_decode_reg) begin
      if (ctrl_reg[MTC_BIT_MODE]) begin
        result = {enc36(in24[15:12]), enc36(in24[11:8]), enc36(in24[7:4]),
                  enc36(in24[3:0])};
      end else begin
        for (int i = 0; i < 12; i++) begin
          result[2*i+1] = in24[i];
          result[2*i] = ~in24[i];
        end
      end
    end else begin
      if (ctrl_reg[MTC_BIT_MODE]) begin
        d0 = dec36(in24[5:0]);
        d1 = dec36(in24[11:6]);
        d2 = dec36(in24[17:12]);
        d3 = dec36(in24[23:18]);
        result = {8'h00, d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
        result_err = d0[4] | d1[4] | d2[4] | d3[4];
      end else begin
        for (int i = 0; i < 12; i++) begin
          result[i] = in24[2*i+1];
          if (in24[2*i+1] == in24[2*i]) begin
            result_err = 1'b1;
          end
        end
      end
    end
  end

  // operation sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= MTC_IDLE;
      cnt_reg <= 2'h0;
      op_decode_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        MTC_IDLE: begin
          if (start_fwd || start_rev) begin
            state_reg <= MTC_BUSY;
            cnt_reg <= MTC_OP_CYCLES;
            op_decode_reg <= start_rev;
          end
        end
        MTC_BUSY: begin
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            state_reg <= MTC_DONE;
          end
        end
        MTC_DONE: begin
          state_reg <= MTC_IDLE;
        end
        default: state_reg <= MTC_IDLE;
      endcase
    end
  end

  // control register: writable bits, start bits clear when done
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= MTC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_wdata & MTC_CTRL_WMASK;
    end else if (state_reg == MTC_DONE) begin
      ctrl_reg[MTC_BIT_FWD] <= 1'b0;
      ctrl_reg[MTC_BIT_REV] <= 1'b0;
    end
  end

  // ready and error flags; a control write clears them, completion sets ready, a failed decode sets error
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
      error_reg <= 1'b0;
    end else begin
      if (state_reg == MTC_DONE) begin
        ready_reg <= 1'b1;
      end else if (wr_ctrl) begin
        ready_reg <= 1'b0;
      end
      // the error is set only when a decode finds an invalid symbol or pair; a control write clears it, but that set wins in the same cycle
      if (state_reg == MTC_DONE && op_decode_reg && result_err) begin
        error_reg <= 1'b1;
      end else if (wr_ctrl) begin
        error_reg <= 1'b0;
      end
    end
  end

  // dma byte lanes: big-endian puts index 0 on the high byte
  assign lane_sel[0] = 8'(ctrl_reg[MTC_BIT_ENDIAN] ? 2 : 0);
  assign lane_sel[1] = 8'h01;
  assign lane_sel[2] = 8'(ctrl_reg[MTC_BIT_ENDIAN] ? 0 : 2);

  // data bytes: bus write, dma write, or result load
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_low_reg <= MTC_DATA_RESET;
      data_mid_reg <= MTC_DATA_RESET;
      data_high_reg <= MTC_DATA_RESET;
    end else if (state_reg == MTC_DONE) begin
      {data_high_reg, data_mid_reg, data_low_reg} <= result;
    end else if (reg_wr && hit_page) begin
      if (reg_addr == MTC_ADDR_DATA_LOW) data_low_reg <= reg_wdata;
      if (reg_addr == MTC_ADDR_DATA_MIDDLE) data_mid_reg <= reg_wdata;
      if (reg_addr == MTC_ADDR_DATA_HIGH) data_high_reg <= reg_wdata;
    end else if (dma_wr && ctrl_reg[MTC_BIT_DMA] && dma_idx != 2'h3) begin
      unique case (lane_sel[dma_idx][1:0])
        2'h0: data_low_reg <= dma_wdata;
        2'h1: data_mid_reg <= dma_wdata;
        default: data_high_reg <= dma_wdata;
      endcase
    end
  end

  // registered read data, page-decoded; other addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && hit_page) begin
      unique case (reg_addr)
        MTC_ADDR_DATA_LOW: reg_rdata <= data_low_reg;
        MTC_ADDR_DATA_MIDDLE: reg_rdata <= data_mid_reg;
        MTC_ADDR_DATA_HIGH: reg_rdata <= data_high_reg;
        MTC_ADDR_CONTROL: reg_rdata <= {ready_reg, error_reg, ctrl_reg[5:0]};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // busy level from a flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_reg == MTC_IDLE) ? (start_fwd || start_rev) : (state_reg == MTC_BUSY);
    end
  end

endmodule : mtc_coder

// File: dv/mtc_coder_sva.sv
`timescale 1ns/1ns
module mtc_coder_sva
  import mtc_pkg::*;
(
  // watched ports
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // page hits; control writes count only while idle
  wire pg = reg_page == MTC_PAGE;
  wire rd = reg_rd && pg;
  wire ua = !(reg_addr inside {[8'hC2:8'hC5]});
  wire cw = reg_wr && pg && reg_addr == 8'hC5 && !busy;
  // busy rises on the start edge, spans two counted cycles and the done cycle
  sequence run_s; busy [*3] ##1 !busy; endsequence
  a_enc_run: assert property (cw && reg_wdata[5] |=> run_s) else $error("enc span");
  a_dec_run: assert property (cw && reg_wdata[4] |=> run_s) else $error("dec span");
  a_no_start: assert property (cw && reg_wdata[5:4] == 2'b00 |=> !busy [*2])
    else $error("busy");
  a_reset_quiet: assert property ($rose(rst_n) |-> !busy && reg_rdata == 8'h00)
    else $error("reset");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("idle");
  a_off_page: assert property (reg_rd && !pg |=> reg_rdata == 8'h00) else $error("pg");
  a_unmapped_zero: assert property (rd && ua |=> reg_rdata == 8'h00) else $error("ua");
  a_bit3_zero: assert property (rd && reg_addr == 8'hC5 |=> !reg_rdata[3])
    else $error("b3");
endmodule : mtc_coder_sva
bind mtc_coder mtc_coder_sva mtc_coder_sva_i (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .reg_page(reg_page),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .busy(busy)
);

// File: dv/mtc_host.sv
`timescale 1ns/1ns
module mtc_host
  import mtc_pkg::*;
(
  // clock in, bus out
  input wire logic clk_sys,
  output logic [7:0] reg_page,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic dma_wr,
  output logic [1:0] dma_idx,
  output logic [7:0] dma_wdata
);
  // idle bus
  initial {reg_page, reg_addr, reg_wr, reg_rd, reg_wdata, dma_wr, dma_idx, dma_wdata} = '0;
  // page first, strobe over one edge, stale data inverted
  task automatic acc(input logic [7:0] p, a, d, input logic w);
    {reg_page, reg_addr, reg_wdata, reg_wr, reg_rd} = {p, a, d, w, !w};
    @(posedge clk_sys) #10;
    {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
    // one idle edge, so a following call never re-raises a strobe in this step
    @(posedge clk_sys) #10;
  endtask : acc
  // one dma byte
  task automatic dma(input logic [1:0] i, input logic [7:0] d);
    {dma_idx, dma_wdata, dma_wr} = {i, d, 1'b1};
    @(posedge clk_sys) #10;
    {dma_wr, dma_wdata} = {1'b0, ~d};
    // idle edge between bytes keeps the write pulse from toggling twice in a step
    @(posedge clk_sys) #10;
  endtask : dma
endmodule : mtc_host

// File: dv/manchester_3of6_coder_bench.sv
`timescale 1ns/1ns
module manchester_3of6_coder_bench;
  import mtc_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, rd_q = 1'b0, reg_wr, reg_rd, dma_wr, busy;
  logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, dma_wdata, ev, exp_q[$];
  logic [1:0] dma_idx;
  logic [23:0] d, e;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  // block and core
  mtc_coder mtc_coder_i (.*);
  mtc_host mtc_host_i (.*);
  initial forever #50 clk_sys = ~clk_sys;
  // strobe seen; hang ceiling
  always @(posedge clk_sys) begin
    rd_q <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // answer stands the cycle after
  always @(negedge clk_sys) begin
    if (rd_q === 1'b1) begin
      ev = exp_q.pop_front();
      num_checks++;
      if (reg_rdata !== ev) begin
        n_mismatch++;
        $display("MISMATCH %0t %h %h", $time, reg_rdata, ev);
      end
    end
  end
  task automatic wr(input logic [7:0] a, v);
    mtc_host_i.acc(MTC_PAGE, a, v, 1'b1);
  endtask : wr
  // note first, then strobe
  task automatic rd(input logic [7:0] a, v, p = MTC_PAGE);
    exp_q.push_back(v);
    mtc_host_i.acc(p, a, 8'h00, 1'b0);
  endtask : rd
  task automatic d3(input logic w, input logic [23:0] v);
    for (int i = 0; i < 3; i++)
      if (w) wr(8'hC2 + 8'(i), v[8*i+:8]);
      else rd(8'hC2 + 8'(i), v[8*i+:8]);
  endtask : d3
  // start, wait out busy, spare cycle, flags
  task automatic op(input logic [7:0] c, f);
    wr(8'hC5, c);
    for (int k = 0; k < 9 && busy !== 1'b0; k++) @(posedge clk_sys) #10;
    @(posedge clk_sys) #10;
    rd(8'hC5, f);
  endtask : op
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(32'h36e8da5a));
    d = 24'($urandom);
    repeat (3) @(posedge clk_sys) #10;
    rst_n = 1'b1;
    d3(1'b0, 24'h0);
    rd(8'hC5, 8'h00);
    rd(8'hC6, 8'h00);
    rd(8'hC2, 8'h00, 8'h00);
    wr(8'hC5, 8'hC8);
    rd(8'hC5, 8'h00);
    $display("test 1 done");
    d3(1'b1, 24'h00F0F0);
    op(8'h21, 8'h81);
    d3(1'b0, 24'hA56A56);
    op(8'h11, 8'h81);
    d3(1'b0, 24'h00F0F0);
    d3(1'b1, 24'hFFFFFF);
    op(8'h11, 8'hC1);
    $display("test 2 done");
    d3(1'b1, 24'h0);
    op(8'h10, 8'hC0);
    for (int i = 0; i < 12; i++) e[2*i+:2] = {d[i], ~d[i]};
    d3(1'b1, d);
    op(8'h20, 8'h80);
    d3(1'b0, e);
    op(8'h10, 8'h80);
    d3(1'b0, {12'h000, d[11:0]});
    $display("test 3 done");
    wr(8'hC5, 8'h06);
    for (int i = 0; i < 3; i++) mtc_host_i.dma(2'(i), d[8*(2-i)+:8]);
    wr(8'hC5, 8'h00);
    mtc_host_i.dma(2'd0, ~d[7:0]);
    d3(1'b0, d);
    // little-endian lanes: index 0 low, index 2 high; index 3 ignored
    wr(8'hC5, 8'h04);
    for (int i = 0; i < 3; i++) mtc_host_i.dma(2'(i), ~d[8*i+:8]);
    mtc_host_i.dma(2'd3, d[7:0]);
    d3(1'b0, ~d);
    $display("test 4 done");
    // mid-run reset clears data and control again
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys) #10;
    rst_n = 1'b1;
    d3(1'b0, 24'h0);
    rd(8'hC5, 8'h00);
    $display("test 5 done");
    #50;
    wrap_up();
  end
endmodule : manchester_3of6_coder_bench
